// ==== overcharge_protection_monitor.sv ====
// Over-charge protection supervisor with APB registers and interrupt
//
// Overview of operation
// [R1] Comparators powered 2 ms per 125 ms
// [R2] Host holds analog selects low normally
// [R3] Over-current watched every cycle
// [R4] Monitor mode keeps comparators powered continuously
// [R5] First over-threshold starts detection delay
// [R6] Delay expiry with cell high: charge off
// [R7] Protection entry leaves discharge drive alone
// [R8] Charge bit writable, drive held in protection
// [R9] Discharge bit stays live during protection
// [R10] All below return: leave, charge on
// [R11] Two config bits choose over-charge threshold
// [R12] Threshold selections kept in persistent storage
// [R13] Charge bit one drives low, FET on
// [R14] Status bit 2 ORs mode with charge-enable
// [R15] Falling back before expiry cancels delay
// [R16] Delay uses powered samples only, held between
`timescale 1ns/1ps
`default_nettype none
`include "oprot_consts.svh"
module overcharge_protection_monitor
   import oprot_pkg::*;
#(
   parameter int unsigned SAMPLE_CYC    = `SAMPLE_CYC,
   parameter int unsigned SAMPLE_ON_CYC = `SAMPLE_ON_CYC,
   parameter int unsigned OV_DELAY_CYC  = `OV_DELAY_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        analog_select_bit2,
   input  wire logic        analog_select_bit1,
   input  wire logic        analog_select_bit0,
   input  wire logic [3:0]  cell_above_ov,
   input  wire logic [3:0]  cell_above_ovr,
   input  wire logic        cell_below_ce,
   input  wire logic        overcurrent_detect,
   output var  logic        comparator_power,
   output var  logic        overcharge_thresh_sel_hi,
   output var  logic        overcharge_thresh_sel_lo,
   output var  logic [1:0]  overdischarge_thresh_sel,
   output var  logic [1:0]  overcurrent_thresh_sel,
   output var  logic        charge_fet_drive,
   output var  logic        discharge_fet_drive,
   output var  logic        irq
);
   // Supervision state
   ov_state_e         state;
   ov_state_e         next_state;
   logic              over_seen;          // Latched: some cell above threshold
   logic              all_below_ret;      // Latched: every cell below return
   logic              delay_expired;      // Detection delay done
   logic              oc_flag;            // Over-current sampled level
   logic              cell_charge_enable_off;
   logic              charge_fet_ctrl_bit;
   logic              dsg_ctrl;
   logic [`IRQ_W-1:0] irq_status;         // Sticky events
   logic [`IRQ_W-1:0] irq_mask;           // Enables onto irq

   // Bus decode
   wire        monitor_mode  = analog_select_bit2 | analog_select_bit1 | analog_select_bit0;
   wire        acc_done      = psel & penable & pready;
   wire        acc_wait      = psel & penable & ~pready;
   wire        wr_done       = acc_done & pwrite;
   wire        hit_cfg       = (paddr == `OFS_CONFIG);
   wire        hit_ctl       = (paddr == `OFS_CONTROL);
   wire        hit_stat      = (paddr == `OFS_STATUS);
   wire        hit_ist       = (paddr == `OFS_IRQ_STATUS);
   wire        hit_imsk      = (paddr == `OFS_IRQ_MASK);
   wire        hit_any       = hit_cfg | hit_ctl | hit_stat | hit_ist | hit_imsk;
   wire        wr_cfg        = wr_done & hit_cfg;
   wire        wr_ctl        = wr_done & hit_ctl;
   wire        wr_ist        = wr_done & hit_ist;
   wire        wr_imsk       = wr_done & hit_imsk;

   // Protection events
   wire        enter_prot    = (state != S_PROTECT) && (next_state == S_PROTECT);
   wire        release_prot  = (state == S_PROTECT) && (next_state == S_NORMAL);
   wire        oc_rise       = overcurrent_detect & ~oc_flag;
   wire [`IRQ_W-1:0] events  = {oc_rise, release_prot, enter_prot};

   // Release turns the charge FET on by setting the control bit itself
   wire        next_chg_ctrl = release_prot ? 1'b1 :                        // R10
                               wr_ctl ? pwdata[`CTL_CHG] : charge_fet_ctrl_bit; // R8
   wire        next_dsg_ctrl = wr_ctl ? pwdata[`CTL_DSG] : dsg_ctrl;           // R9

   // Status view: bit 2 folds in the charge-enable condition when it is on
   wire        ov_status     = (state == S_PROTECT) | (cell_below_ce & ~cell_charge_enable_off); // R14
   wire [31:0] status_word   = {29'h0, ov_status, 1'b0, oc_flag};
   wire [31:0] config_word   = {25'h0, cell_charge_enable_off, overcurrent_thresh_sel,
                                overdischarge_thresh_sel, overcharge_thresh_sel_hi,
                                overcharge_thresh_sel_lo};
   wire [31:0] control_word  = {30'h0, dsg_ctrl, charge_fet_ctrl_bit};
   wire [31:0] rd_mux        = hit_cfg  ? config_word :
                               hit_ctl  ? control_word :
                               hit_stat ? status_word :
                               hit_ist  ? {29'h0, irq_status} :
                               hit_imsk ? {29'h0, irq_mask} : 32'h0;

   // Comparator power: duty-cycled normally, continuous in monitor mode
   protection_sample_timer #(
      .PERIOD_CYC (SAMPLE_CYC),
      .ON_CYC     (SAMPLE_ON_CYC)
   ) u_sample (
      .ref_clk          (ref_clk),
      .rst              (rst),
      .continuous       (monitor_mode),                                       // R4
      .comparator_power (comparator_power)                                    // R1
   );

   // Detection delay runs in real time while a high cell is latched
   detect_delay_timer #(
      .LIMIT (OV_DELAY_CYC)
   ) u_delay (
      .ref_clk (ref_clk),
      .rst     (rst),
      .run     (state == S_DETECT),                                           // R5
      .expired (delay_expired)
   );

   // Comparator results only count while powered; held in between
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         over_seen     <= 1'b0;
         all_below_ret <= 1'b1;
      end else if (comparator_power) begin                                  // R16
         over_seen     <= |cell_above_ov;
         all_below_ret <= ~|cell_above_ovr;
      end
   end

   // Over-current is not duty-cycled
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         oc_flag <= 1'b0;
      end else begin
         oc_flag <= overcurrent_detect;                                     // R3
      end
   end

   // Next-state logic
   always_comb begin
      next_state = state;
      case (state)
         S_NORMAL: begin
            if (over_seen) begin
               next_state = S_DETECT;                                        // R5
            end
         end
         S_DETECT: begin
            if (!over_seen) begin
               next_state = S_NORMAL;                                        // R15
            end else if (delay_expired) begin
               next_state = S_PROTECT;                                       // R6
            end
         end
         S_PROTECT: begin
            if (all_below_ret) begin
               next_state = S_NORMAL;                                        // R10
            end
         end
         default: begin
            next_state = S_NORMAL;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= S_NORMAL;
      end else begin
         state <= next_state;
      end
   end

   // Control bits; writes are taken even during protection
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         charge_fet_ctrl_bit <= 1'b0;
         dsg_ctrl            <= 1'b0;
      end else begin
         charge_fet_ctrl_bit <= next_chg_ctrl;                              // R8
         dsg_ctrl            <= next_dsg_ctrl;                              // R9
      end
   end

   // FET drives: low turns the FET on; protection forces only charge off
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         charge_fet_drive    <= 1'b1;
         discharge_fet_drive <= 1'b1;
      end else begin
         charge_fet_drive    <= (next_state == S_PROTECT) | ~next_chg_ctrl;  // R6 R13
         discharge_fet_drive <= ~next_dsg_ctrl;                              // R7 R9
      end
   end

   // Threshold selections change only by a configuration write
   // They stand in for the persistent cells; rst models first power-up
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {cell_charge_enable_off, overcurrent_thresh_sel, overdischarge_thresh_sel,
          overcharge_thresh_sel_hi, overcharge_thresh_sel_lo} <= `CFG_RESET;
      end else if (wr_cfg) begin                                            // R11 R12
         overcharge_thresh_sel_lo <= pwdata[`CFG_OV_LO];
         overcharge_thresh_sel_hi <= pwdata[`CFG_OV_HI];
         overdischarge_thresh_sel <= pwdata[`CFG_OD_LSB +: 2];
         overcurrent_thresh_sel   <= pwdata[`CFG_OC_LSB +: 2];
         cell_charge_enable_off   <= pwdata[`CFG_CE_OFF];
      end
   end

   // Sticky event bits: a new event wins over a write-one clear
   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_W; gi = gi + 1) begin : g_irq
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               irq_status[gi] <= 1'b0;
            end else begin
               irq_status[gi] <= events[gi] | (irq_status[gi] & ~(wr_ist & pwdata[gi]));
            end
         end
      end
   endgenerate

   // Mask and interrupt level
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_mask <= 3'h0;
         irq      <= 1'b0;
      end else begin
         if (wr_imsk) begin
            irq_mask <= pwdata[`IRQ_W-1:0];
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // APB answer: one wait cycle, data and error latched with pready
   // The fixed wait keeps read data registered for a clean output path
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= acc_wait;
         pslverr <= acc_wait & ~hit_any;
         if (acc_wait) begin
            prdata <= pwrite ? 32'h0 : rd_mux;
         end
      end
   end

   // Checks next to the logic they guard
   AST_CHG_OFF_IN_PROT: assert property (@(posedge ref_clk) disable iff (rst) // R6
      state == S_PROTECT |-> charge_fet_drive)
      else $error("charge FET not off during protection");
   AST_ENTER_PROT: assert property (@(posedge ref_clk) disable iff (rst) // R6
      state == S_DETECT && over_seen && delay_expired |=> state == S_PROTECT && charge_fet_drive)
      else $error("protection not entered on delay expiry");
   AST_START_DELAY: assert property (@(posedge ref_clk) disable iff (rst) // R5
      state == S_NORMAL && over_seen |=> state == S_DETECT ##1 !delay_expired)
      else $error("detection delay not started");
   AST_CANCEL: assert property (@(posedge ref_clk) disable iff (rst) // R15
      state == S_DETECT && !over_seen |=> state == S_NORMAL)
      else $error("delay not cancelled on fall-back");
   AST_DSG_LIVE: assert property (@(posedge ref_clk) disable iff (rst) // R9
      wr_ctl |=> discharge_fet_drive == !$past(pwdata[`CTL_DSG]))
      else $error("discharge drive ignores control write");
   AST_HOLD_CHG: assert property (@(posedge ref_clk) disable iff (rst) // R8
      state == S_PROTECT && !all_below_ret && wr_ctl |=> charge_fet_drive
      && charge_fet_ctrl_bit == $past(pwdata[`CTL_CHG]))
      else $error("charge write not held during protection");
   AST_RELEASE: assert property (@(posedge ref_clk) disable iff (rst) // R10
      state == S_PROTECT && all_below_ret |=> state == S_NORMAL && !charge_fet_drive
      && ($past(wr_ctl) || $stable(discharge_fet_drive)))
      else $error("release did not turn charge FET on");
   AST_MONITOR: assert property (@(posedge ref_clk) disable iff (rst) // R4
      monitor_mode ##1 monitor_mode |-> comparator_power)
      else $error("comparators off in monitor mode");
   AST_SAMPLE_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // R16
      !comparator_power |=> $stable(over_seen) && $stable(all_below_ret))
      else $error("comparator result changed while unpowered");
   AST_OC: assert property (@(posedge ref_clk) disable iff (rst) // R3
      overcurrent_detect |=> oc_flag)
      else $error("over-current missed");
   AST_STATUS_OV: assert property (@(posedge ref_clk) disable iff (rst) // R14
      acc_wait && !pwrite && hit_stat && state == S_PROTECT |=> prdata[`STAT_OV])
      else $error("status bit 2 misses protection mode");
   AST_THRESH: assert property (@(posedge ref_clk) disable iff (rst) // R11
      wr_cfg |=> {overcharge_thresh_sel_hi, overcharge_thresh_sel_lo} == $past(pwdata[1:0]))
      else $error("threshold select not written");
endmodule
`default_nettype wire

// ==== oprot_consts.svh ====
// Register offsets, field positions, reset values and timing figures of the protection monitor
`ifndef OPROT_CONSTS_SVH
`define OPROT_CONSTS_SVH
// Register byte offsets
`define OFS_CONFIG      12'h000
`define OFS_CONTROL     12'h004
`define OFS_STATUS      12'h008
`define OFS_IRQ_STATUS  12'h00c
`define OFS_IRQ_MASK    12'h010
// Configuration fields
`define CFG_OV_LO       0
`define CFG_OV_HI       1
`define CFG_OD_LSB      2
`define CFG_OC_LSB      4
`define CFG_CE_OFF      6
`define CFG_RESET       7'h00
// Control fields
`define CTL_CHG         0
`define CTL_DSG         1
// Status fields
`define STAT_OC         0
`define STAT_OD         1
`define STAT_OV         2
// Interrupt events
`define IRQ_ENTER       0
`define IRQ_RELEASE     1
`define IRQ_OC          2
`define IRQ_W           3
// Timing figures in nanoseconds and the clock period
`define CLK_PERIOD_NS   100
`define T_SAMPLE_NS     125000000
`define T_SAMPLE_ON_NS  2000000
`define T_OV_NS         1000000000
`define SAMPLE_CYC      (`T_SAMPLE_NS / `CLK_PERIOD_NS)
`define SAMPLE_ON_CYC   (`T_SAMPLE_ON_NS / `CLK_PERIOD_NS)
`define OV_DELAY_CYC    (`T_OV_NS / `CLK_PERIOD_NS)
`endif

// ==== oprot_pkg.sv ====
// Types shared by the protection monitor files
`default_nettype none
package oprot_pkg;
   // Over-charge supervision states
   typedef enum logic [1:0] {
      S_NORMAL,
      S_DETECT,
      S_PROTECT
   } ov_state_e;
endpackage
`default_nettype wire

// ==== protection_sample_timer.sv ====
// Duty-cycle timer that powers the voltage comparators
`timescale 1ns/1ps
`default_nettype none
module protection_sample_timer #(
   parameter int unsigned PERIOD_CYC = 1250000,
   parameter int unsigned ON_CYC     = 20000
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic continuous,
   output var  logic comparator_power
);
   logic [20:0] cnt;   // Position inside the sample period

   // Free-running period counter; comparators powered at its start
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt              <= 21'h000000;
         comparator_power <= 1'b0;
      end else begin
         cnt              <= (cnt == 21'(PERIOD_CYC - 1)) ? 21'h000000 : cnt + 21'h000001;
         comparator_power <= continuous || (cnt < 21'(ON_CYC));
      end
   end
endmodule
`default_nettype wire

// ==== detect_delay_timer.sv ====
// Detection delay timer: expires after LIMIT cycles of continuous run
`timescale 1ns/1ps
`default_nettype none
module detect_delay_timer #(
   parameter int unsigned LIMIT = 10000000
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic run,
   output var  logic expired
);
   logic [23:0] cnt;   // Elapsed cycles since run rose

   // Dropping run cancels the count at once
   always_ff @(posedge ref_clk) begin
      if (rst || !run) begin
         cnt     <= 24'h000000;
         expired <= 1'b0;
      end else if (cnt == 24'(LIMIT - 1)) begin
         expired <= 1'b1;
      end else begin
         cnt <= cnt + 24'h000001;
      end
   end
endmodule
`default_nettype wire

// ==== cell_pack_model.sv ====
// Cell pack and host select pins as seen from the protection monitor
`timescale 1ns/1ps
`default_nettype none
module cell_pack_model (
   input  wire logic       ref_clk,
   input  wire logic       comparator_power,
   input  wire logic [3:0] set_over,
   input  wire logic [3:0] set_ret,
   input  wire logic [2:0] set_select,
   output var  logic       analog_select_bit2,
   output var  logic       analog_select_bit1,
   output var  logic       analog_select_bit0,
   output var  logic [3:0] cell_above_ov,
   output var  logic [3:0] cell_above_ovr
);
   logic tog = 1'b0; // Junk source for comparators that are switched off

   // Flips every cycle so a stale unpowered sample is never mistaken for valid
   always @(posedge ref_clk) begin
      tog <= ~tog;
   end

   // Host keeps every select low unless it wants monitor mode
   assign analog_select_bit2 = set_select[2];
   assign analog_select_bit1 = set_select[1];
   assign analog_select_bit0 = set_select[0];

   // Unpowered comparators give no real answer, only a changing pattern
   assign cell_above_ov  = comparator_power ? set_over : {4{tog}};
   assign cell_above_ovr = comparator_power ? set_ret : {4{~tog}};
endmodule
`default_nettype wire

// ==== tb_overcharge_protection_monitor.sv ====
// Self-checking bench for the over-charge protection monitor
`timescale 1ns/1ps
`default_nettype none
`include "oprot_consts.svh"
module tb_overcharge_protection_monitor
   import oprot_pkg::*;
;
   localparam int SC = 40; // Short sample period
   localparam int SO = 4;  // Short powered window
   localparam int OD = 20; // Short detection delay
   logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        as2, as1, as0, cell_below_ce, overcurrent_detect, comparator_power;
   logic [3:0]  cell_above_ov, cell_above_ovr, set_over, set_ret;
   logic        sel_hi, sel_lo, chg, dsg, irq;
   logic [1:0]  od_sel, oc_sel;
   logic [2:0]  set_select; // Host select pins, all low for sampling
   logic [33:0] notes[$]; // Pending answers: read flag, error flag, data
   logic [33:0] cur;      // Note being compared
   int          n_errors = 0;
   int          tests_run = 0;

   overcharge_protection_monitor #(.SAMPLE_CYC(SC), .SAMPLE_ON_CYC(SO), .OV_DELAY_CYC(OD)) dut (
      .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .analog_select_bit2(as2), .analog_select_bit1(as1), .analog_select_bit0(as0),
      .cell_above_ov(cell_above_ov), .cell_above_ovr(cell_above_ovr), .cell_below_ce(cell_below_ce),
      .overcurrent_detect(overcurrent_detect), .comparator_power(comparator_power),
      .overcharge_thresh_sel_hi(sel_hi), .overcharge_thresh_sel_lo(sel_lo),
      .overdischarge_thresh_sel(od_sel), .overcurrent_thresh_sel(oc_sel),
      .charge_fet_drive(chg), .discharge_fet_drive(dsg), .irq(irq));

   cell_pack_model pack (
      .ref_clk(ref_clk), .comparator_power(comparator_power), .set_over(set_over),
      .set_ret(set_ret), .set_select(set_select), .analog_select_bit2(as2),
      .analog_select_bit1(as1), .analog_select_bit0(as0),
      .cell_above_ov(cell_above_ov), .cell_above_ovr(cell_above_ovr));

   // Free-running bench clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Counts every comparison, reports and counts mismatches
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One bus transfer; the expected answer is noted before it starts
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
      int n;
      notes.push_back({~wr, err, wr ? 32'h0 : d});
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) check("bus answer", 32'h0, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, exp, 1'b0);
   endtask

   // Waits, bounded, until the charge drive shows the wanted level
   task automatic wait_chg(input logic want, input int lim, output int n);
      n = 0;
      while (chg !== want && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Takes the oldest note whenever a transfer completes and compares it
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1) begin
         cur = notes.pop_front();
         check("pslverr", {31'h0, pslverr}, {31'h0, cur[32]});
         if (cur[33]) check("prdata", prdata, cur[31:0]);
      end
   end

   // Cuts a hang short; the whole run needs only a few hundred cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      int n;
      logic [6:0] cfg;
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
      {set_over, set_ret, set_select, cell_below_ce, overcurrent_detect} = 13'h0;
      void'($urandom(32'h9b68));
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      check("fets off after reset", {30'h0, dsg, chg}, 32'h3);
      rd(`OFS_CONFIG, 32'h0);
      rd(`OFS_CONTROL, 32'h0);
      rd(`OFS_IRQ_STATUS, 32'h0);
      // Random threshold selections reach their pins and read back
      cfg = 7'($urandom());
      wr(`OFS_CONFIG, {25'h0, cfg});
      rd(`OFS_CONFIG, {25'h0, cfg});
      check("ov select", {30'h0, sel_hi, sel_lo}, {30'h0, cfg[1:0]});
      check("od oc select", {28'h0, oc_sel, od_sel}, {28'h0, cfg[5:2]});
      // Charge-enable term joins status bit 2 only while enabled
      cell_below_ce <= 1'b1;
      wr(`OFS_CONFIG, 32'h0);
      rd(`OFS_STATUS, 32'h4);
      wr(`OFS_CONFIG, 32'h40);
      rd(`OFS_STATUS, 32'h0);
      cell_below_ce <= 1'b0;
      wr(`OFS_CONFIG, 32'h0);
      // Unmapped place refused, read-only status ignores writes
      apb(1'b1, 12'h014, 32'hffff_ffff, 1'b1);
      apb(1'b0, 12'h014, 32'h0, 1'b1);
      wr(`OFS_STATUS, 32'h7);
      rd(`OFS_STATUS, 32'h0);
      // Every control code drives both FET pins with inverted sense
      for (int v = 0; v < 4; v++) begin
         wr(`OFS_CONTROL, 32'(v));
         repeat (2) @(posedge ref_clk);
         check("fet drives", {30'h0, dsg, chg}, {30'h0, ~2'(v)});
      end
      // Powered cycles in one sample period, then monitor mode
      n = 0;
      repeat (SC) begin
         @(posedge ref_clk);
         n += int'(comparator_power);
      end
      check("powered cycles", 32'(n), 32'(SO));
      // Each select pin alone switches to monitor mode
      for (int b = 0; b < 3; b++) begin
         set_select <= 3'h1 << b;
         repeat (3) @(posedge ref_clk);
         n = 0;
         repeat (SC) begin
            @(posedge ref_clk);
            n += int'(comparator_power);
         end
         check("monitor powered", 32'(n), 32'(SC));
      end
      // Short excursion above threshold is forgotten before expiry
      set_over <= 4'h1;
      set_ret <= 4'h1;
      repeat (OD / 2) @(posedge ref_clk);
      set_over <= 4'h0;
      set_ret <= 4'h0;
      wait_chg(1'b1, 3 * OD, n);
      check("charge stays on", {31'h0, chg}, 32'h0);
      set_select <= 3'h0;
      // Over-current seen while sampling, masked then unmasked, cleared
      overcurrent_detect <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(`OFS_STATUS, 32'h1);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(`OFS_IRQ_MASK, 32'h7);
      repeat (2) @(posedge ref_clk);
      check("irq raised", {31'h0, irq}, 32'h1);
      overcurrent_detect <= 1'b0;
      wr(`OFS_IRQ_STATUS, 32'h4);
      rd(`OFS_IRQ_STATUS, 32'h0);
      check("irq cleared", {31'h0, irq}, 32'h0);
      // Cell held high: protection after the full delay, discharge kept
      set_over <= 4'h4;
      set_ret <= 4'h4;
      wait_chg(1'b1, SC + OD + 10, n);
      check("delay not cut short", {31'h0, n >= OD}, 32'h1);
      check("charge off", {31'h0, chg}, 32'h1);
      check("discharge kept", {31'h0, dsg}, 32'h0);
      rd(`OFS_STATUS, 32'h4);
      rd(`OFS_IRQ_STATUS, 32'h1);
      wr(`OFS_CONTROL, 32'h1);
      repeat (3) @(posedge ref_clk);
      check("charge held off", {31'h0, chg}, 32'h1);
      check("discharge follows", {31'h0, dsg}, 32'h1);
      wr(`OFS_CONTROL, 32'h2);
      repeat (3) @(posedge ref_clk);
      check("discharge back on", {31'h0, dsg}, 32'h0);
      // All cells below return level: charge switched on automatically
      set_over <= 4'h0;
      set_ret <= 4'h0;
      wait_chg(1'b0, SC + 10, n);
      check("charge on after release", {31'h0, chg}, 32'h0);
      check("discharge unchanged", {31'h0, dsg}, 32'h0);
      rd(`OFS_CONTROL, 32'h3);
      rd(`OFS_IRQ_STATUS, 32'h3);
      wr(`OFS_IRQ_STATUS, 32'h3);
      repeat (2) @(posedge ref_clk);
      check("irq low", {31'h0, irq}, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
